// >>> hdl/frrfc_pkg.sv
package frrfc_pkg;
    localparam int AW_DEF = 10;
    localparam int MARK_BYTES_DEF = 32;
    localparam int BYTES_PER_WORD = 4;
    localparam int OFF_RST = 7;
    localparam logic [11:0] A_STATUS = 12'h000;
    localparam logic [11:0] A_LEVEL = 12'h004;
    localparam logic [11:0] A_AE_OFF = 12'h008;
    localparam logic [11:0] A_AF_OFF = 12'h00C;
    localparam logic [11:0] A_IRQ_STAT = 12'h010;
    localparam logic [11:0] A_IRQ_MASK = 12'h014;
    localparam int IRQ_W = 4;
    localparam int IRQ_AF = 0;
    localparam int IRQ_AE = 1;
    localparam int IRQ_MARK_REF = 2;
    localparam int IRQ_WR_REF = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam int ST_EF = 0;
    localparam int ST_AE = 1;
    localparam int ST_AF = 2;
    localparam int ST_FULL = 3;
    localparam int ST_RT = 4;
    localparam int ST_MARK = 5;
    localparam int ST_FALL_THROUGH_MODE = 6;
    localparam int ST_SYNC = 7;
    typedef enum logic [1:0] {RT_IDLE, RT_SETUP, RT_FLAGS} frrfc_rt_t;
endpackage : frrfc_pkg

// >>> hdl/frrfc_flag.sv
module frrfc_flag (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sync,
    input wire logic i_early,
    input wire logic i_hit,
    output logic o_flag_n
);
    logic flag_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            flag_q <= 1'b1;
        else
            flag_q <= ~i_hit;
    end

    // Async mode follows the level at once; sync mode lags one edge unless i_early is set
    assign o_flag_n = (i_sync && !i_early) ? flag_q : ~i_hit;

    chk_flag_lag: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sync && !i_early && !$past(i_rst)) |-> (flag_q == !$past(i_hit)))
        else $error("sync flag does not lag its level by one edge");
endmodule : frrfc_flag

// >>> hdl/frrfc_top.sv
// Local design decisions: the APB interface to the registers and the placing of the registers.
module frrfc_top #(
    parameter int AW = frrfc_pkg::AW_DEF,
    parameter int MARK_BYTES = frrfc_pkg::MARK_BYTES_DEF
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ,
    input wire logic I_FLAG_TIMING_SELECT,
    input wire logic I_FALL_THROUGH_MODE,
    input wire logic I_WRITE_EN_N,
    input wire logic [AW-1:0] I_OFFSET_DATA,
    output logic O_MEM_WE,
    output logic [AW-1:0] O_MEM_WADDR,
    input wire logic I_READ_SELECT_N,
    input wire logic I_READ_EN_N,
    input wire logic I_RETRANSMIT_REQUEST_N,
    input wire logic I_MARK,
    output logic [AW-1:0] O_MEM_RADDR,
    output logic O_OUT_LOAD,
    output logic O_OUT_ENABLE,
    input wire logic I_OFFSET_LOAD_N,
    input wire logic I_SERIAL_EN,
    input wire logic I_SERIAL_IN,
    output logic [AW-1:0] O_OFFSET_Q,
    output logic O_OFFSET_Q_VALID,
    output logic O_EMPTY_FLAG_N,
    output logic O_FULL_FLAG_N,
    output logic O_ALMOST_EMPTY_FLAG_N,
    output logic O_ALMOST_FULL_FLAG_N
);
    localparam int CW = AW + 2;
    localparam logic [CW-1:0] DEPTH_STD = CW'(1) << AW;
    localparam logic [CW-1:0] MARK_WORDS = CW'(MARK_BYTES / frrfc_pkg::BYTES_PER_WORD);
    localparam logic [5:0] SBITS = 6'(2 * AW);

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == frrfc_pkg::A_STATUS) || (a == frrfc_pkg::A_LEVEL) ||
            (a == frrfc_pkg::A_AE_OFF) || (a == frrfc_pkg::A_AF_OFF) ||
            (a == frrfc_pkg::A_IRQ_STAT) || (a == frrfc_pkg::A_IRQ_MASK);
    endfunction : reg_hit

    logic sync_q;
    logic fall_through_mode_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] ret_q;
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW-1:0] mark_ptr_q;
    logic outv_q;
    logic mark_q;
    logic rt_prev_q;
    logic oe_q;
    logic ef_q;
    frrfc_pkg::frrfc_rt_t rt_st_q;
    logic [AW-1:0] ae_off_q;
    logic [AW-1:0] af_off_q;
    logic [5:0] sbit_q;
    logic wsel_q;
    logic rsel_q;
    logic prd_prev_q;
    logic [frrfc_pkg::IRQ_W-1:0] stat_q;
    logic [frrfc_pkg::IRQ_W-1:0] mask_q;
    logic [frrfc_pkg::IRQ_W-1:0] set_d;
    logic [frrfc_pkg::IRQ_W-1:0] clr_d;
    logic ae_prev_q;
    logic af_prev_q;
    logic [31:0] rdata_d;
    logic [7:0] status_d;

    logic [CW-1:0] depth_eff;
    logic [CW-1:0] ram_cnt;
    logic [CW-1:0] cap_cnt;
    logic [CW-1:0] count_d;
    logic full;
    logic ld_mode;
    logic rd_raw;
    logic rd_req;
    logic wr_req;
    logic wr_do;
    logic rt_busy;
    logic rt_go;
    logic rt_block;
    logic fall;
    logic adv;
    logic pop;
    logic ae_hit;
    logic af_hit;
    logic mark_req;
    logic mark_ok;
    logic prd;
    logic apb_setup;
    logic apb_wr;
    logic apb_rd;

    // Straps are caught while reset is held and kept until the next reset
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            sync_q <= I_FLAG_TIMING_SELECT;
            fall_through_mode_q <= I_FALL_THROUGH_MODE;
        end
    end

    assign depth_eff = fall_through_mode_q ? DEPTH_STD + CW'(1) : DEPTH_STD;
    assign ram_cnt = count_q - CW'(outv_q);
    // A mark makes the retained span, not the unread span, the limit
    assign cap_cnt = mark_q ? ret_q : count_q;
    assign full = cap_cnt >= depth_eff;
    assign ld_mode = !I_OFFSET_LOAD_N;
    assign rd_raw = !I_READ_EN_N && !I_READ_SELECT_N;
    assign rd_req = rd_raw && !ld_mode;
    assign wr_req = !I_WRITE_EN_N && !ld_mode;
    assign wr_do = wr_req && !full;
    assign rt_busy = rt_st_q != frrfc_pkg::RT_IDLE;
    // Edge start: a request held low does not restart the sequence
    assign rt_go = !I_RETRANSMIT_REQUEST_N && rt_prev_q && mark_q && !rt_busy;
    assign rt_block = rt_busy || rt_go;
    assign fall = fall_through_mode_q && !outv_q && ram_cnt != '0 && !rt_go;
    // No select history is checked, so an early enable consumes the first word
    assign adv = fall_through_mode_q && outv_q && rd_req && !rt_block;
    assign pop = fall_through_mode_q ? adv : (rd_req && count_q != '0 && !rt_block);
    assign count_d = rt_go ? ret_q + CW'(wr_do) : count_q + CW'(wr_do) - CW'(pop);
    assign ae_hit = count_q <= {2'b00, ae_off_q};
    assign af_hit = count_q >= depth_eff - {2'b00, af_off_q};
    assign mark_req = I_MARK && !mark_q;
    assign mark_ok = count_q >= MARK_WORDS;
    assign prd = ld_mode && rd_raw && !prd_prev_q;

    assign O_MEM_WE = wr_do;
    assign O_MEM_WADDR = wptr_q;
    assign O_MEM_RADDR = rptr_q;
    assign O_OUT_LOAD = fall || (pop && ram_cnt != '0);
    assign O_OUT_ENABLE = oe_q;
    assign O_EMPTY_FLAG_N = ef_q;
    assign O_FULL_FLAG_N = ~full;

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            count_q <= '0;
            wptr_q <= '0;
            rptr_q <= '0;
            outv_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            if (wr_do)
                wptr_q <= wptr_q + AW'(1);
            if (rt_go)
                rptr_q <= mark_ptr_q;
            else if (O_OUT_LOAD)
                rptr_q <= rptr_q + AW'(1);
            if (rt_go)
                outv_q <= 1'b0;
            else if (fall)
                outv_q <= 1'b1;
            else if (adv && ram_cnt == '0)
                outv_q <= 1'b0;
        end
    end

    // Mark holds while its input stays high; retained count grows with writes
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            mark_q <= 1'b0;
            mark_ptr_q <= '0;
            ret_q <= '0;
        end
        else if (!I_MARK)
            mark_q <= 1'b0;
        else if (mark_req && mark_ok)
        begin
            mark_q <= 1'b1;
            mark_ptr_q <= (fall_through_mode_q && outv_q) ? rptr_q - AW'(1) : rptr_q;
            ret_q <= count_q + CW'(wr_do);
        end
        else if (mark_q)
            ret_q <= ret_q + CW'(wr_do);
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            rt_st_q <= frrfc_pkg::RT_IDLE;
            rt_prev_q <= 1'b1;
        end
        else
        begin
            rt_prev_q <= I_RETRANSMIT_REQUEST_N;
            case (rt_st_q)
                frrfc_pkg::RT_IDLE:
                    if (rt_go)
                        rt_st_q <= frrfc_pkg::RT_SETUP;
                frrfc_pkg::RT_SETUP:
                    rt_st_q <= frrfc_pkg::RT_FLAGS;
                frrfc_pkg::RT_FLAGS:
                    rt_st_q <= frrfc_pkg::RT_IDLE;
                default:
                    rt_st_q <= frrfc_pkg::RT_IDLE;
            endcase
        end
    end

    // Empty is held low through retransmit setup and released after it
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            ef_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            ef_q <= ~(rt_block || (fall_through_mode_q ? !outv_q : count_q == '0));
            oe_q <= !I_READ_SELECT_N;
        end
    end

    frrfc_flag u_ae_flag (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sync(sync_q),
        .i_early(rt_st_q == frrfc_pkg::RT_FLAGS && !fall_through_mode_q),
        .i_hit(ae_hit),
        .o_flag_n(O_ALMOST_EMPTY_FLAG_N)
    );

    frrfc_flag u_af_flag (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_sync(sync_q),
        .i_early(1'b0),
        .i_hit(af_hit),
        .o_flag_n(O_ALMOST_FULL_FLAG_N)
    );

    // Offsets: pins in load mode take priority over the bus
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            ae_off_q <= AW'(frrfc_pkg::OFF_RST);
            af_off_q <= AW'(frrfc_pkg::OFF_RST);
            sbit_q <= '0;
            wsel_q <= 1'b0;
        end
        else if (ld_mode && I_SERIAL_EN)
        begin
            if (sbit_q < 6'(AW))
                ae_off_q <= {I_SERIAL_IN, ae_off_q[AW-1:1]};
            else
                af_off_q <= {I_SERIAL_IN, af_off_q[AW-1:1]};
            sbit_q <= (sbit_q == SBITS - 6'd1) ? 6'd0 : sbit_q + 6'd1;
        end
        else if (ld_mode && !I_WRITE_EN_N)
        begin
            if (wsel_q)
                af_off_q <= I_OFFSET_DATA;
            else
                ae_off_q <= I_OFFSET_DATA;
            wsel_q <= ~wsel_q;
        end
        else if (!ld_mode)
        begin
            sbit_q <= '0;
            wsel_q <= 1'b0;
            if (apb_wr && I_PADDR == frrfc_pkg::A_AE_OFF)
                ae_off_q <= I_PWDATA[AW-1:0];
            if (apb_wr && I_PADDR == frrfc_pkg::A_AF_OFF)
                af_off_q <= I_PWDATA[AW-1:0];
        end
    end

    // Back-to-back offset reads are ignored rather than corrupting the order
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            O_OFFSET_Q <= '0;
            O_OFFSET_Q_VALID <= 1'b0;
            rsel_q <= 1'b0;
            prd_prev_q <= 1'b0;
        end
        else
        begin
            prd_prev_q <= ld_mode && rd_raw;
            O_OFFSET_Q_VALID <= prd;
            if (prd)
            begin
                O_OFFSET_Q <= rsel_q ? af_off_q : ae_off_q;
                rsel_q <= ~rsel_q;
            end
            else if (!ld_mode)
                rsel_q <= 1'b0;
        end
    end

    assign apb_setup = I_PSEL && !I_PENABLE;
    assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
    assign apb_rd = I_PSEL && I_PENABLE && !I_PWRITE;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !reg_hit(I_PADDR);
    assign O_IRQ = |(stat_q & mask_q);

    always_comb
    begin
        status_d = '0;
        status_d[frrfc_pkg::ST_EF] = O_EMPTY_FLAG_N;
        status_d[frrfc_pkg::ST_AE] = O_ALMOST_EMPTY_FLAG_N;
        status_d[frrfc_pkg::ST_AF] = O_ALMOST_FULL_FLAG_N;
        status_d[frrfc_pkg::ST_FULL] = full;
        status_d[frrfc_pkg::ST_RT] = rt_busy;
        status_d[frrfc_pkg::ST_MARK] = mark_q;
        status_d[frrfc_pkg::ST_FALL_THROUGH_MODE] = fall_through_mode_q;
        status_d[frrfc_pkg::ST_SYNC] = sync_q;
        case (I_PADDR)
            frrfc_pkg::A_STATUS: rdata_d = 32'(status_d);
            frrfc_pkg::A_LEVEL: rdata_d = 32'(count_q);
            frrfc_pkg::A_AE_OFF: rdata_d = 32'(ae_off_q);
            frrfc_pkg::A_AF_OFF: rdata_d = 32'(af_off_q);
            frrfc_pkg::A_IRQ_STAT: rdata_d = 32'(stat_q);
            frrfc_pkg::A_IRQ_MASK: rdata_d = 32'(mask_q);
            default: rdata_d = '0;
        endcase
    end

    always_comb
    begin
        set_d = '0;
        set_d[frrfc_pkg::IRQ_AF] = af_prev_q && !O_ALMOST_FULL_FLAG_N;
        set_d[frrfc_pkg::IRQ_AE] = ae_prev_q && !O_ALMOST_EMPTY_FLAG_N;
        set_d[frrfc_pkg::IRQ_MARK_REF] = mark_req && !mark_ok;
        set_d[frrfc_pkg::IRQ_WR_REF] = wr_req && full;
        clr_d = (apb_rd && I_PADDR == frrfc_pkg::A_IRQ_STAT) ? stat_q : '0;
    end

    // Read data is latched in setup so the access phase needs no wait
    always_ff @(posedge I_MCLK)
    begin
        if (I_RST)
        begin
            O_PRDATA <= '0;
            mask_q <= frrfc_pkg::IRQ_MASK_RST;
            stat_q <= '0;
            ae_prev_q <= 1'b1;
            af_prev_q <= 1'b1;
        end
        else
        begin
            if (apb_setup && !I_PWRITE)
                O_PRDATA <= rdata_d;
            if (apb_wr && I_PADDR == frrfc_pkg::A_IRQ_MASK)
                mask_q <= I_PWDATA[frrfc_pkg::IRQ_W-1:0];
            // A new event in the clearing cycle survives the clear
            stat_q <= (stat_q & ~clr_d) | set_d;
            ae_prev_q <= O_ALMOST_EMPTY_FLAG_N;
            af_prev_q <= O_ALMOST_FULL_FLAG_N;
        end
    end

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    chk_early_read_drop: assert property (
        ($fell(I_READ_SELECT_N) && !I_READ_EN_N && fall_through_mode_q && outv_q && !ld_mode
        && !rt_block && ram_cnt != '0) |-> O_OUT_LOAD ##1 O_OUT_ENABLE)
        else $error("early read enable did not consume the first word");
    chk_first_fall: assert property (
        (fall_through_mode_q && !outv_q && ram_cnt != '0 && !rt_go) |=> outv_q)
        else $error("first word did not fall through");
    chk_mark_threshold: assert property (
        $rose(mark_q) |-> $past(count_q) >= MARK_WORDS)
        else $error("mark set below byte threshold");
    chk_rt_setup_len: assert property (
        rt_go |=> !O_EMPTY_FLAG_N ##2 (rt_st_q == frrfc_pkg::RT_IDLE))
        else $error("retransmit setup length wrong");
    chk_rt_empty_rel: assert property (
        ($fell(rt_busy) && !fall_through_mode_q && count_q != '0) |=> O_EMPTY_FLAG_N)
        else $error("empty not released after retransmit setup");
    chk_mark_no_overwrite: assert property (
        (mark_q && ret_q >= depth_eff) |-> !O_MEM_WE)
        else $error("write passed the marked location");
    chk_ae_early: assert property (
        (rt_st_q == frrfc_pkg::RT_FLAGS && !fall_through_mode_q) |-> O_ALMOST_EMPTY_FLAG_N == !ae_hit)
        else $error("almost-empty not updated early in retransmit");
    chk_serial_shift: assert property (
        (ld_mode && I_SERIAL_EN && sbit_q < 6'(AW)) |=> ae_off_q[AW-1] == $past(I_SERIAL_IN))
        else $error("serial offset bit not taken");
    chk_af_release: assert property (
        (sync_q && $fell(af_hit)) |=> O_ALMOST_FULL_FLAG_N)
        else $error("almost-full not released one cycle after read");
    chk_ae_release: assert property (
        (sync_q && !rt_busy && $fell(ae_hit)) |=> O_ALMOST_EMPTY_FLAG_N)
        else $error("almost-empty not released one cycle after write");
    chk_depth_extra: assert property (
        (fall_through_mode_q && !mark_q && count_q == DEPTH_STD) |-> O_FULL_FLAG_N)
        else $error("fall-through depth lacks its extra word");

    cov_mark_set: cover property ($rose(mark_q));
    cov_retransmit: cover property (rt_go ##3 O_EMPTY_FLAG_N);
    cov_offset_read: cover property (O_OFFSET_Q_VALID ##2 O_OFFSET_Q_VALID);
endmodule : frrfc_top

// >>> testbench/frrfc_peer.sv
module frrfc_peer (
    input wire logic i_clk,
    input wire logic i_wr_go,
    input wire logic i_rd_go,
    input wire logic i_rt_go,
    input wire logic i_spaced,
    input wire logic i_eager,
    output logic o_write_en_n,
    output logic o_read_select_n,
    output logic o_read_en_n,
    output logic o_retransmit_request_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_write_en_n = 1'h1;
        o_read_select_n = 1'h1;
        o_read_en_n = 1'h1;
        o_retransmit_request_n = 1'h1;
    end
    always @(posedge i_clk)
    begin
        o_write_en_n <= !i_wr_go;
        o_read_select_n <= !i_rd_go;
        // Enable trails select, so the word already on the bus is seen first
        // Eager mode drops enable with select on purpose, to reach the lost-word path
        o_read_en_n <= !(i_rd_go && (i_eager || (!o_read_select_n
            && (o_read_en_n || !i_spaced))));
        // A running read defers the request
        o_retransmit_request_n <= !(i_rt_go && o_read_en_n);
    end
endmodule : frrfc_peer

// >>> testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 10;
    localparam logic [19:0] SV = 20'h5A3C6;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic fts = 1'h1;
    logic ftm = 1'h0;
    logic mark = 1'h0;
    logic load_n = 1'h1;
    logic ser_en = 1'h0;
    logic ser_in = 1'h0;
    logic wr_go = 1'h0;
    logic rd_go = 1'h0;
    logic rt_go = 1'h0;
    logic spaced = 1'h0;
    logic eager = 1'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, wen_n, mem_we, rsel_n, ren_n, rt_n, err;
    logic out_load, out_en, off_v, ef_n, ff_n, ae_n, af_n;
    logic [AW-1:0] waddr, raddr, off_q;
    logic [AW-1:0] offq[$];
    int n_fail = 0;
    int checks = 0;
    int n_we = 0;
    int n_ld = 0;
    int n_cyc = 0;
    int we0;
    int ld0;

    frrfc_top #(.AW(AW)) frrfc_top_i (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq),
        .I_FLAG_TIMING_SELECT(fts), .I_FALL_THROUGH_MODE(ftm), .I_WRITE_EN_N(wen_n),
        .I_OFFSET_DATA({AW{1'h0}}), .O_MEM_WE(mem_we), .O_MEM_WADDR(waddr),
        .I_READ_SELECT_N(rsel_n), .I_READ_EN_N(ren_n), .I_RETRANSMIT_REQUEST_N(rt_n),
        .I_MARK(mark), .O_MEM_RADDR(raddr), .O_OUT_LOAD(out_load), .O_OUT_ENABLE(out_en),
        .I_OFFSET_LOAD_N(load_n), .I_SERIAL_EN(ser_en), .I_SERIAL_IN(ser_in),
        .O_OFFSET_Q(off_q), .O_OFFSET_Q_VALID(off_v), .O_EMPTY_FLAG_N(ef_n),
        .O_FULL_FLAG_N(ff_n), .O_ALMOST_EMPTY_FLAG_N(ae_n), .O_ALMOST_FULL_FLAG_N(af_n));

    frrfc_peer frrfc_peer_i (.i_clk(clk), .i_wr_go(wr_go), .i_rd_go(rd_go),
        .i_rt_go(rt_go), .i_spaced(spaced), .i_eager(eager), .o_write_en_n(wen_n),
        .o_read_select_n(rsel_n), .o_read_en_n(ren_n), .o_retransmit_request_n(rt_n));

    initial
    begin
        forever #25 clk = ~clk;
    end

    // Run is about 2200 cycles; the ceiling leaves wide margin
    always @(posedge clk)
    begin
        n_cyc <= n_cyc + 1;
        if (mem_we === 1'h1)
            n_we <= n_we + 1;
        if (out_load === 1'h1)
            n_ld <= n_ld + 1;
        if (off_v === 1'h1)
            offq.push_back(off_q);
        if (n_cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic do_reset(input logic s, input logic f);
        @(posedge clk);
        fts <= s;
        ftm <= f;
        rst <= 1'h1;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        // Registered flags take their level at the first edge after release
        @(posedge clk);
        @(negedge clk);
    endtask : do_reset

    // The peer adds one cycle, so n go cycles give n writes
    task automatic wr(input int n);
        @(posedge clk);
        wr_go <= 1'h1;
        repeat (n) @(posedge clk);
        wr_go <= 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : wr

    // Select leads enable by a cycle, hence n+1 go cycles for n reads
    task automatic rdn(input int n);
        @(posedge clk);
        rd_go <= 1'h1;
        repeat (n + 1) @(posedge clk);
        rd_go <= 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : rdn

    initial
    begin
        do_reset(1'h1, 1'h0);
        chk("reset flags", 32'h2, {ef_n, ae_n, af_n, irq});
        apb(1'h0, frrfc_pkg::A_STATUS, 32'h0);
        chk("status sync", 32'h84, rd);
        apb(1'h0, frrfc_pkg::A_AE_OFF, 32'h0);
        chk("ae offset", 32'h7, rd);
        apb(1'h0, 12'hFF0, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        wr(7);
        chk("ae at seven", 32'h0, ae_n);
        @(posedge clk);
        mark <= 1'h1;
        @(posedge clk);
        mark <= 1'h0;
        apb(1'h0, frrfc_pkg::A_IRQ_STAT, 32'h0);
        chk("mark refused", 32'h4, rd & 32'h4);
        @(negedge clk);
        chk("irq masked", 32'h0, irq);
        wr(1);
        chk("ae at eight", 32'h1, ae_n);
        @(posedge clk);
        mark <= 1'h1;
        apb(1'h0, frrfc_pkg::A_STATUS, 32'h0);
        chk("mark set", 32'h20, rd & 32'h20);
        ld0 = n_ld;
        rdn(3);
        chk("reads", 32'h3, n_ld - ld0);
        chk("raddr", 32'h3, 32'(raddr));
        @(posedge clk);
        rt_go <= 1'h1;
        @(posedge clk);
        rt_go <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("rt ef low", 32'h0, ef_n);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("rt ef high", 32'h1, ef_n);
        chk("rt raddr", 32'h0, 32'(raddr));
        rdn(5);
        apb(1'h1, frrfc_pkg::A_IRQ_MASK, 32'h8);
        we0 = n_we;
        wr(1030);
        chk("marked writes", 32'h3F8, n_we - we0);
        chk("marked flags", 32'h0, {ff_n, af_n});
        chk("irq raised", 32'h1, irq);
        apb(1'h0, frrfc_pkg::A_IRQ_STAT, 32'h0);
        chk("write refused", 32'h8, rd & 32'h8);
        @(negedge clk);
        chk("irq cleared", 32'h0, irq);
        rdn(2);
        chk("af held", 32'h0, af_n);
        rdn(1);
        chk("af released", 32'h1, af_n);
        @(posedge clk);
        mark <= 1'h0;
        load_n <= 1'h0;
        for (int i = 0; i < 2 * AW; i++)
        begin
            @(posedge clk);
            ser_en <= 1'h1;
            ser_in <= SV[i];
        end
        @(posedge clk);
        ser_en <= 1'h0;
        spaced <= 1'h1;
        offq.delete();
        rdn(4);
        chk("readback count", 32'h2, offq.size());
        chk("readback ae", 32'(SV[9:0]), 32'(offq[0]));
        chk("readback af", 32'(SV[19:10]), 32'(offq[1]));
        @(posedge clk);
        load_n <= 1'h1;
        spaced <= 1'h0;
        apb(1'h0, frrfc_pkg::A_AF_OFF, 32'h0);
        chk("af offset", 32'(SV[19:10]), rd);
        do_reset(1'h0, 1'h1);
        apb(1'h0, frrfc_pkg::A_STATUS, 32'h0);
        chk("status async", 32'h44, rd);
        ld0 = n_ld;
        wr(1);
        chk("fall through", 32'h1, n_ld - ld0);
        chk("ft ef", 32'h1, ef_n);
        we0 = n_we;
        wr(1030);
        chk("ft writes", 32'h400, n_we - we0);
        chk("ft waddr", 32'h1, 32'(waddr));
        apb(1'h0, frrfc_pkg::A_LEVEL, 32'h0);
        chk("ft level", 32'h401, rd);
        chk("ft full", 32'h0, {ff_n, af_n});
        @(posedge clk);
        eager <= 1'h1;
        ld0 = n_ld;
        rdn(0);
        chk("early read", 32'h1, n_ld - ld0);
        apb(1'h0, frrfc_pkg::A_LEVEL, 32'h0);
        chk("early level", 32'h400, rd);
        complete_run();
    end
endmodule : tb
